//--- verilog/hrng_pkg.sv
`default_nettype none
package hrng_pkg;
    // ------------------------------------------------------------
    // word and state sizes
    // ------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int STATE_W = 128;
    localparam int NW_W = 8;
    localparam int SEED_WORDS = 4;

    // ------------------------------------------------------------
    // conditioning and health figures
    // ------------------------------------------------------------
    // raw bits xor-folded into one conditioned bit
    localparam int FOLD = 2;
    // entropy per conditioned bit the folding aims at
    localparam real MIN_ENTROPY = 0.997;
    localparam int RUN_LIMIT = 32;
    localparam int WIN = 256;
    localparam int ONES_LO = 96;
    localparam int ONES_HI = 160;

    // ------------------------------------------------------------
    // reset values and mixing constants
    // ------------------------------------------------------------
    localparam logic [STATE_W-1:0] STATE_RST = 128'h0;
    localparam logic [WORD_W-1:0] K_OUT = 32'h9e3779b9;
    localparam logic [WORD_W-1:0] K_UPD = 32'h7f4a7c15;
    localparam logic [WORD_W-1:0] K_SEED = 32'h85ebca6b;

    typedef enum logic {T_IDLE, T_RUN} hrng_true_random_source_st_t;
endpackage : hrng_pkg
`default_nettype wire

//--- verilog/hrng_if.sv
`default_nettype none
interface hrng_ent_if;
    logic raw_bit;
    logic tot_fail;
    logic defect;
    logic startup_ok;
    modport mon (input raw_bit, output tot_fail, defect, startup_ok);
    modport top (output raw_bit, input tot_fail, defect, startup_ok);
endinterface : hrng_ent_if

interface hrng_drbg_if;
    logic [hrng_pkg::WORD_W-1:0] seed_word;
    logic seed_valid;
    logic seed_ready;
    logic reseed;
    logic busy;
    logic seeded;
    logic [hrng_pkg::WORD_W-1:0] out_word;
    logic out_valid;
    logic out_ready;
    modport gen (input seed_word, seed_valid, reseed, out_ready,
                 output seed_ready, busy, seeded, out_word, out_valid);
    modport top (output seed_word, seed_valid, reseed, out_ready,
                 input seed_ready, busy, seeded, out_word, out_valid);
endinterface : hrng_drbg_if
`default_nettype wire

//--- verilog/hrng_health.sv
`default_nettype none
module hrng_health #(
    parameter int RUN_MAX = hrng_pkg::RUN_LIMIT,
    parameter int WIN_LEN = hrng_pkg::WIN
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // entropy monitor
    hrng_ent_if.mon ent
);
    import hrng_pkg::*;
    localparam int RW = $clog2(RUN_MAX + 1);
    localparam int WW = $clog2(WIN_LEN);
    localparam int OW = $clog2(WIN_LEN + 1);

    logic last_r, last_nxt, tot_r, tot_nxt, def_r, def_nxt, ok_r, ok_nxt;
    logic [RW-1:0] run_r, run_nxt;
    logic [WW-1:0] win_r, win_nxt;
    logic [OW-1:0] ones_r, ones_nxt, ones_end;
    logic win_end, bad;

    always_comb begin
        ones_end = ones_r + OW'(ent.raw_bit);
        win_end = (win_r == WW'(WIN_LEN - 1));
        bad = (ones_end < OW'(ONES_LO)) || (ones_end > OW'(ONES_HI));
        last_nxt = ent.raw_bit;
        if (ent.raw_bit != last_r) begin
            run_nxt = RW'(1);
        end else if (run_r != RW'(RUN_MAX)) begin
            run_nxt = run_r + RW'(1);
        end else begin
            run_nxt = run_r;
        end
        tot_nxt = tot_r | (run_nxt == RW'(RUN_MAX));
        win_nxt = win_end ? '0 : win_r + WW'(1);
        ones_nxt = win_end ? '0 : ones_end;
        def_nxt = def_r | (win_end & bad);
        ok_nxt = ok_r | (win_end & ~bad & ~def_r);
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            last_r <= 1'b0;
            run_r <= '0;
            win_r <= '0;
            ones_r <= '0;
            tot_r <= 1'b0;
            def_r <= 1'b0;
            ok_r <= 1'b0;
        end else begin
            last_r <= last_nxt;
            run_r <= run_nxt;
            win_r <= win_nxt;
            ones_r <= ones_nxt;
            tot_r <= tot_nxt;
            def_r <= def_nxt;
            ok_r <= ok_nxt;
        end
    end

    assign ent.tot_fail = tot_r;
    assign ent.defect = def_r;
    assign ent.startup_ok = ok_r;

    property p_tot;
        @(posedge mclk) disable iff (!rst_b)
        (run_r == RW'(RUN_MAX - 1) && ent.raw_bit == last_r)
            |=> ent.tot_fail;
    endproperty
    a_tot: assert property (p_tot) else $error("stuck source missed");

    property p_win;
        @(posedge mclk) disable iff (!rst_b)
        (win_end && bad) |=> ent.defect && !$rose(ent.startup_ok);
    endproperty
    a_win: assert property (p_win) else $error("window defect missed");
endmodule : hrng_health
`default_nettype wire

//--- verilog/hrng_drbg.sv
`default_nettype none
module hrng_drbg (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // seed in, words out
    hrng_drbg_if.gen d
);
    import hrng_pkg::*;
    localparam int CW = $clog2(SEED_WORDS);

    function automatic logic [WORD_W-1:0] rotl(input logic [WORD_W-1:0] x,
                                               input int n);
        rotl = (x << n) | (x >> (WORD_W - n));
    endfunction : rotl

    // light arx mixing; not a vetted hash, strength rests on the seed
    function automatic logic [STATE_W-1:0] mix(input logic [STATE_W-1:0] s,
                                               input logic [WORD_W-1:0] k);
        logic [WORD_W-1:0] a, b, c, e;
        a = s[127:96] + k;
        b = s[95:64];
        c = s[63:32];
        e = s[31:0];
        for (int i = 0; i < 2; i++) begin
            a = a + b;
            e = rotl(e ^ a, 16);
            c = c + e;
            b = rotl(b ^ c, 12);
            a = a + b;
            e = rotl(e ^ a, 8);
            c = c + e;
            b = rotl(b ^ c, 7);
        end
        mix = {a, b, c, e};
    endfunction : mix

    logic [STATE_W-1:0] st_r, st_nxt, m_out;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic seeded_r, seeded_nxt, pend_r, pend_nxt, outv_r, outv_nxt, take;
    logic [WORD_W-1:0] out_r, out_nxt;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        seeded_nxt = seeded_r;
        pend_nxt = pend_r;
        out_nxt = out_r;
        outv_nxt = outv_r;
        m_out = mix(st_r, K_OUT);
        take = d.out_valid && d.out_ready;
        if (pend_r) begin
            outv_nxt = 1'b0;
            if (d.seed_valid) begin
                st_nxt = mix({st_r[127:32], st_r[31:0] ^ d.seed_word},
                             K_SEED);
                cnt_nxt = cnt_r + CW'(1);
                if (cnt_r == CW'(SEED_WORDS - 1)) begin
                    pend_nxt = 1'b0;
                    seeded_nxt = 1'b1;
                    cnt_nxt = '0;
                end
            end
        end else if (!outv_r || take) begin
            out_nxt = m_out[127:96] ^ m_out[31:0];
            outv_nxt = 1'b1;
            // feed-forward xor keeps the update one-way
            st_nxt = st_r ^ mix(st_r, K_UPD);
        end
        if (d.reseed) begin
            pend_nxt = 1'b1;
            cnt_nxt = '0;
            outv_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_r <= STATE_RST;
            cnt_r <= '0;
            seeded_r <= 1'b0;
            pend_r <= 1'b1;
            out_r <= '0;
            outv_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            seeded_r <= seeded_nxt;
            pend_r <= pend_nxt;
            out_r <= out_nxt;
            outv_r <= outv_nxt;
        end
    end

    assign d.seed_ready = pend_r;
    assign d.busy = pend_r;
    assign d.seeded = seeded_r;
    assign d.out_word = out_r;
    assign d.out_valid = outv_r & ~pend_r;

    property p_unseeded;
        @(posedge mclk) disable iff (!rst_b)
        !seeded_r |-> !d.out_valid;
    endproperty
    a_unseeded: assert property (p_unseeded) else $error("unseeded out");

    property p_reseed;
        @(posedge mclk) disable iff (!rst_b)
        d.reseed |=> d.busy && !d.out_valid;
    endproperty
    a_reseed: assert property (p_reseed) else $error("reseed ignored");

    property p_adv;
        @(posedge mclk) disable iff (!rst_b)
        take |=> st_r != $past(st_r);
    endproperty
    a_adv: assert property (p_adv) else $error("state not advanced");
endmodule : hrng_drbg
`default_nettype wire

//--- verilog/hrng_top.sv
// Contract
// - deterministic state is seeded from the physical entropy path
// - user may request a reseed from the physical path at any time
// - deterministic output is delivered as 32-bit words
// - state update hides earlier outputs even if state is known
// - earlier outputs do not let later outputs be predicted
// - total-failure test runs from start; a failure blocks all output
// - after total failure no word using later raw bits leaves the block
// - online test gates output until power-up pass, stops it on defect
// - continuous online test finds defects within a bounded window
// - physical output is a whole number of 32-bit words per request
// - conditioning targets average entropy above 0.997 per bit
`default_nettype none
module hrng_top #(
    parameter int FOLD_N = hrng_pkg::FOLD
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // raw noise pin
    input wire logic noise_in,
    // physical word path
    input wire logic true_random_source_req,
    input wire logic [hrng_pkg::NW_W-1:0] true_random_source_nwords,
    output logic [hrng_pkg::WORD_W-1:0] true_random_source_word,
    output logic true_random_source_valid,
    input wire logic true_random_source_ready,
    output logic true_random_source_busy,
    // deterministic path
    output logic [hrng_pkg::WORD_W-1:0] drbg_word,
    output logic drbg_valid,
    input wire logic drbg_ready,
    input wire logic reseed_req,
    output logic reseed_busy,
    output logic drbg_seeded,
    // health status
    output logic startup_done,
    output logic fail_flag,
    output logic fail_total,
    output logic fail_defect
);
    import hrng_pkg::*;

    localparam int FW = $clog2(FOLD_N + 1);
    localparam int BW = $clog2(WORD_W);
    localparam logic [BW-1:0] BCNT_LAST = BW'(WORD_W - 1);

    // ------------------------------------------------------------
    // noise synchroniser
    // ------------------------------------------------------------
    logic n_s1_r, n_s2_r;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            n_s1_r <= 1'b0;
            n_s2_r <= 1'b0;
        end else begin
            n_s1_r <= noise_in;
            n_s2_r <= n_s1_r;
        end
    end

    // ------------------------------------------------------------
    // health monitor and generator
    // ------------------------------------------------------------
    hrng_ent_if ent ();
    hrng_drbg_if dif ();

    assign ent.raw_bit = n_s2_r;

    hrng_health u_health (
        .mclk (mclk),
        .rst_b (rst_b),
        .ent (ent)
    );

    hrng_drbg u_drbg (
        .mclk (mclk),
        .rst_b (rst_b),
        .d (dif)
    );

    logic fail_w, ok_w;

    assign fail_w = ent.tot_fail | ent.defect;
    assign ok_w = ent.startup_ok & ~fail_w;
    assign fail_flag = fail_w;
    assign fail_total = ent.tot_fail;
    assign fail_defect = ent.defect;
    assign startup_done = ent.startup_ok;

    // ------------------------------------------------------------
    // conditioning: fold raw bits, pack words
    // ------------------------------------------------------------
    logic par_r, par_nxt, par, fold_done;
    logic [FW-1:0] fcnt_r, fcnt_nxt;
    logic [BW-1:0] bcnt_r, bcnt_nxt;
    logic [WORD_W-1:0] acc_r, acc_nxt, word_r, word_nxt;
    logic full_r, full_nxt;
    logic seed_take, true_random_source_load, consume;

    assign seed_take = dif.seed_valid & dif.seed_ready;
    assign consume = seed_take | true_random_source_load;

    always_comb begin
        par = par_r ^ n_s2_r;
        fold_done = (fcnt_r == FW'(FOLD_N - 1));
        par_nxt = fold_done ? 1'b0 : par;
        fcnt_nxt = fold_done ? '0 : fcnt_r + FW'(1);
        acc_nxt = acc_r;
        bcnt_nxt = bcnt_r;
        word_nxt = word_r;
        full_nxt = full_r & ~consume;
        if (fold_done) begin
            acc_nxt = {acc_r[WORD_W-2:0], par};
            bcnt_nxt = bcnt_r + BW'(1);
            // a new word is dropped while the old one waits
            if (bcnt_r == BCNT_LAST && !full_nxt) begin
                word_nxt = {acc_r[WORD_W-2:0], par};
                full_nxt = 1'b1;
            end
        end
        if (!ok_w) begin
            // discard bits that may postdate a failure
            par_nxt = 1'b0;
            fcnt_nxt = '0;
            acc_nxt = '0;
            bcnt_nxt = '0;
            full_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            par_r <= 1'b0;
            fcnt_r <= '0;
            acc_r <= '0;
            bcnt_r <= '0;
            word_r <= '0;
            full_r <= 1'b0;
        end else begin
            par_r <= par_nxt;
            fcnt_r <= fcnt_nxt;
            acc_r <= acc_nxt;
            bcnt_r <= bcnt_nxt;
            word_r <= word_nxt;
            full_r <= full_nxt;
        end
    end

    // ------------------------------------------------------------
    // seeding path; seeding outranks the physical consumer
    // ------------------------------------------------------------
    assign dif.seed_word = word_r;
    assign dif.seed_valid = full_r & ok_w;
    assign dif.reseed = reseed_req;
    assign dif.out_ready = drbg_ready & ok_w;
    assign drbg_valid = dif.out_valid & ok_w;
    assign drbg_word = dif.out_word;
    assign reseed_busy = dif.busy;
    assign drbg_seeded = dif.seeded;

    // ------------------------------------------------------------
    // physical word requests
    // ------------------------------------------------------------
    hrng_true_random_source_st_t st_r, st_nxt;
    logic [NW_W-1:0] left_r, left_nxt;
    logic [WORD_W-1:0] tw_r, tw_nxt;
    logic tv_r, tv_nxt;

    assign true_random_source_load = (st_r == T_RUN) && !tv_r && full_r && ok_w &&
                       !dif.seed_ready;

    always_comb begin
        st_nxt = st_r;
        left_nxt = left_r;
        tw_nxt = tw_r;
        tv_nxt = tv_r;
        case (st_r)
            T_IDLE: begin
                if (true_random_source_req && true_random_source_nwords != '0 && ok_w) begin
                    st_nxt = T_RUN;
                    left_nxt = true_random_source_nwords;
                end
            end
            T_RUN: begin
                if (true_random_source_load) begin
                    tw_nxt = word_r;
                    tv_nxt = 1'b1;
                end
                if (true_random_source_valid && true_random_source_ready) begin
                    tv_nxt = 1'b0;
                    left_nxt = left_r - NW_W'(1);
                    if (left_r == NW_W'(1)) begin
                        st_nxt = T_IDLE;
                    end
                end
            end
            default: begin
                st_nxt = T_IDLE;
            end
        endcase
        if (!ok_w) begin
            // a failure cancels the rest of the request
            st_nxt = T_IDLE;
            tv_nxt = 1'b0;
            left_nxt = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_r <= T_IDLE;
            left_r <= '0;
            tw_r <= '0;
            tv_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            left_r <= left_nxt;
            tw_r <= tw_nxt;
            tv_r <= tv_nxt;
        end
    end

    assign true_random_source_word = tw_r;
    assign true_random_source_valid = tv_r & ok_w;
    assign true_random_source_busy = (st_r == T_RUN);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_fail_quiet;
        @(posedge mclk) disable iff (!rst_b)
        fail_flag |-> !true_random_source_valid && !drbg_valid && !dif.seed_valid;
    endproperty
    a_fail_quiet: assert property (p_fail_quiet) else $error("out on fail");

    property p_startup;
        @(posedge mclk) disable iff (!rst_b)
        !startup_done |-> !true_random_source_valid && !drbg_valid && !true_random_source_busy;
    endproperty
    a_startup: assert property (p_startup) else $error("out before pass");

    property p_tot_drop;
        @(posedge mclk) disable iff (!rst_b)
        $rose(fail_total) |=> !full_r && bcnt_r == '0 && !true_random_source_busy;
    endproperty
    a_tot_drop: assert property (p_tot_drop) else $error("stale word kept");

    property p_hold;
        @(posedge mclk) disable iff (!rst_b)
        (true_random_source_valid && !true_random_source_ready) ##1 !fail_flag
            |-> true_random_source_valid && $stable(true_random_source_word);
    endproperty
    a_hold: assert property (p_hold) else $error("word dropped");

    property p_last;
        @(posedge mclk) disable iff (!rst_b)
        (true_random_source_valid && true_random_source_ready && left_r == NW_W'(1)) |=> !true_random_source_busy;
    endproperty
    a_last: assert property (p_last) else $error("count overrun");

    property p_sticky;
        @(posedge mclk) disable iff (!rst_b)
        fail_flag |=> fail_flag ##1 fail_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");

    property p_pack;
        @(posedge mclk) disable iff (!rst_b)
        (fold_done && bcnt_r == BCNT_LAST && !full_r && ok_w) |=> full_r;
    endproperty
    a_pack: assert property (p_pack) else $error("word not packed");

    c_true_random_source: cover property (@(posedge mclk) disable iff (!rst_b)
        true_random_source_valid && true_random_source_ready);
    c_reseed: cover property (@(posedge mclk) disable iff (!rst_b)
        $fell(reseed_busy) && drbg_seeded);
    c_fail: cover property (@(posedge mclk) disable iff (!rst_b)
        $rose(fail_flag));
endmodule : hrng_top
`default_nettype wire

//--- sim/hrng_top_test.sv
`default_nettype none
module hrng_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import hrng_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic noise_in = 1'b0;
    logic true_random_source_req = 1'b0;
    logic [NW_W-1:0] true_random_source_nwords = 8'h00;
    logic [WORD_W-1:0] true_random_source_word;
    logic true_random_source_valid;
    logic true_random_source_ready = 1'b0;
    logic true_random_source_busy;
    logic [WORD_W-1:0] drbg_word;
    logic drbg_valid;
    logic drbg_ready = 1'b0;
    logic reseed_req = 1'b0;
    logic reseed_busy;
    logic drbg_seeded;
    logic startup_done;
    logic fail_flag;
    logic fail_total;
    logic fail_defect;
    int miscompares = 0;
    int checks_done = 0;
    int true_random_source_seen = 0;
    int true_random_source_exp = 0;
    int mode = 0;
    logic [15:0] lfsr_r = 16'h0053;
    logic [7:0] bias_r = 8'h00;
    logic [WORD_W-1:0] last_true_random_source = 32'h0;
    logic [WORD_W-1:0] drbg_q[$];

    always #2.5 mclk = ~mclk;

    hrng_top i_dut (.mclk(mclk), .rst_b(rst_b), .noise_in(noise_in),
        .true_random_source_req(true_random_source_req), .true_random_source_nwords(true_random_source_nwords),
        .true_random_source_word(true_random_source_word), .true_random_source_valid(true_random_source_valid),
        .true_random_source_ready(true_random_source_ready), .true_random_source_busy(true_random_source_busy),
        .drbg_word(drbg_word), .drbg_valid(drbg_valid),
        .drbg_ready(drbg_ready), .reseed_req(reseed_req),
        .reseed_busy(reseed_busy), .drbg_seeded(drbg_seeded),
        .startup_done(startup_done), .fail_flag(fail_flag),
        .fail_total(fail_total), .fail_defect(fail_defect));

    // ----------------------------------------------------------------
    // checking and reporting
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr_f(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
    endfunction : lfsr_f

    task automatic chk1(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask : chk1

    task automatic chk_n(input string nm, input int e, input int g);
        checks_done++;
        if (g != e) begin
            miscompares++;
            $display("[ERR] %s exp %0d got %0d", nm, e, g);
        end
    endtask : chk_n

    task automatic print_verdict;
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // healthy noise from the lfsr; stuck and sparse modes for faults
    always @(posedge mclk) begin
        lfsr_r <= lfsr_f(lfsr_r);
        bias_r <= bias_r + 8'h01;
        case (mode)
            0: noise_in <= lfsr_r[0];
            1: noise_in <= 1'b0;
            default: noise_in <= (bias_r[2:0] == 3'h0);
        endcase
    end

    // every take is logged; nothing may leave while failed
    // sampled mid-cycle so outputs launched at the edge have settled
    always @(negedge mclk) begin
        if (rst_b === 1'b1 && fail_flag === 1'b1) begin
            chk1("valid_in_fail", 1'b0, true_random_source_valid | drbg_valid);
        end
        if (true_random_source_valid === 1'b1 && true_random_source_ready === 1'b1) begin
            true_random_source_seen++;
            chk1("true_random_source_fresh", 1'b1, true_random_source_word !== last_true_random_source);
            last_true_random_source = true_random_source_word;
        end
        if (drbg_valid === 1'b1 && drbg_ready === 1'b1) begin
            chk1("drbg_seeded", 1'b1, drbg_seeded);
            if (drbg_q.size() > 0) begin
                chk1("drbg_fresh", 1'b1, drbg_word !== drbg_q[$]);
            end
            drbg_q.push_back(drbg_word);
        end
    end

    // ----------------------------------------------------------------
    // drivers
    // ----------------------------------------------------------------
    task automatic do_reset;
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        @(negedge mclk);
        chk1("rst_tvalid", 1'b0, true_random_source_valid);
        chk1("rst_dvalid", 1'b0, drbg_valid);
        chk1("rst_fail", 1'b0, fail_flag);
        chk1("rst_rbusy", 1'b1, reseed_busy);
        chk1("rst_seeded", 1'b0, drbg_seeded);
        chk1("rst_start", 1'b0, startup_done);
    endtask : do_reset

    // one physical request; n is the word count handed in
    task automatic true_random_source_run(input logic [NW_W-1:0] n);
        int i;
        @(posedge mclk);
        true_random_source_ready <= 1'b1;
        true_random_source_req <= 1'b1;
        true_random_source_nwords <= n;
        for (i = 0; i < 50 && true_random_source_busy !== 1'b1; i++) @(negedge mclk);
        chk1("true_random_source_taken", 1'b1, true_random_source_busy);
        @(posedge mclk);
        true_random_source_req <= 1'b0;
        true_random_source_exp += int'(n);
        for (i = 0; i < 3000 && true_random_source_busy !== 1'b0; i++) @(negedge mclk);
        chk_n("true_random_source_count", true_random_source_exp, true_random_source_seen);
    endtask : true_random_source_run

    task automatic drbg_take(input int k);
        int i;
        int goal;
        goal = drbg_q.size() + k;
        @(posedge mclk);
        drbg_ready <= 1'b1;
        // leave on the edge of the last take so no extra word slips out
        for (i = 0; i < 500 && drbg_q.size() < goal; i++) @(posedge mclk);
        drbg_ready <= 1'b0;
        chk_n("drbg_count", goal, drbg_q.size());
    endtask : drbg_take

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        int i;
        repeat (8) @(posedge mclk);
        do_reset();
        // early request is ignored
        @(posedge mclk);
        true_random_source_req <= 1'b1;
        true_random_source_nwords <= 8'h02;
        @(posedge mclk);
        true_random_source_req <= 1'b0;
        repeat (3) @(negedge mclk);
        chk1("early_req", 1'b0, true_random_source_busy);
        for (i = 0; i < 2000 && startup_done !== 1'b1; i++) @(negedge mclk);
        chk1("startup", 1'b1, startup_done);
        for (i = 0; i < 3000 && drbg_seeded !== 1'b1; i++) @(negedge mclk);
        chk1("seeded", 1'b1, drbg_seeded);
        // zero words refused
        @(posedge mclk);
        true_random_source_req <= 1'b1;
        true_random_source_nwords <= 8'h00;
        @(posedge mclk);
        true_random_source_req <= 1'b0;
        repeat (3) @(negedge mclk);
        chk1("zero_req", 1'b0, true_random_source_busy);
        // back-to-back requests, random sizes
        for (i = 0; i < 3; i++) begin
            true_random_source_run(8'h01 + {6'h00, lfsr_r[1:0]});
        end
        drbg_take(5);
        // reseed while output waits
        @(posedge mclk);
        reseed_req <= 1'b1;
        @(posedge mclk);
        reseed_req <= 1'b0;
        @(negedge mclk);
        chk1("rs_busy", 1'b1, reseed_busy);
        chk1("rs_valid", 1'b0, drbg_valid);
        for (i = 0; i < 3000 && reseed_busy !== 1'b0; i++) @(negedge mclk);
        chk1("rs_done", 1'b0, reseed_busy);
        @(negedge mclk);
        chk1("rs_valid2", 1'b1, drbg_valid);
        drbg_take(3);
        // stuck source during a running request
        @(posedge mclk);
        true_random_source_ready <= 1'b1;
        true_random_source_req <= 1'b1;
        true_random_source_nwords <= 8'h08;
        drbg_ready <= 1'b1;
        mode <= 1;
        @(posedge mclk);
        true_random_source_req <= 1'b0;
        for (i = 0; i < 200 && fail_total !== 1'b1; i++) @(negedge mclk);
        chk1("tot_fail", 1'b1, fail_total);
        chk1("tot_flag", 1'b1, fail_flag);
        repeat (3) @(negedge mclk);
        chk1("tot_busy", 1'b0, true_random_source_busy);
        chk1("tot_seen", 1'b1, true_random_source_seen < true_random_source_exp + 8);
        drbg_ready <= 1'b0;
        // sparse ones, no long run: only the online test may catch it
        mode <= 2;
        do_reset();
        for (i = 0; i < 1500 && fail_defect !== 1'b1; i++) @(negedge mclk);
        chk1("defect", 1'b1, fail_defect);
        chk1("def_total", 1'b0, fail_total);
        chk1("def_flag", 1'b1, fail_flag);
        print_verdict();
    end

    initial begin
        #400000;
        miscompares++;
        print_verdict();
    end
endmodule : hrng_top_test
`default_nettype wire
